// File: fmx_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// bus host: one-cycle strobes launched at the falling edge
// ------------------------------------------------------------
module fmx_host_model (
	input  wire logic        clock,
	input  wire logic [15:0] reg_rdata,
	output logic [5:0]       reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [15:0]      reg_wdata,
	output logic             irq_ack
);
	// idle bus at time zero
	initial begin
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		irq_ack = 1'b0;
	end
	// write; data inverted once released so stale data is never reused
	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_wdata = ~v;
	endtask
	// read; data taken one cycle after the strobe edge
	task automatic rd(input logic [5:0] a, output logic [15:0] q);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		@(negedge clock);
		q = reg_rdata;
	endtask
	// interrupt acknowledge pulse
	task automatic ack;
		@(negedge clock);
		irq_ack = 1'b1;
		@(negedge clock);
		irq_ack = 1'b0;
	endtask
endmodule

// File: fmx_pkg.sv
package fmx_pkg;
	// ------------------------------------------------------------
	// register offsets (byte offsets in the A16 block)
	// ------------------------------------------------------------
	localparam logic [5:0] FMX_OFS_MAKER    = 6'h00;
	localparam logic [5:0] FMX_OFS_MODEL    = 6'h02;
	localparam logic [5:0] FMX_OFS_STATCTL  = 6'h04;
	localparam logic [5:0] FMX_OFS_SEQCTL   = 6'h06;
	localparam logic [5:0] FMX_OFS_DELAY    = 6'h08;
	localparam logic [5:0] FMX_OFS_ENTRY    = 6'h0A;
	localparam logic [5:0] FMX_OFS_DIRCHAN  = 6'h0C;
	localparam logic [5:0] FMX_OFS_DIRCTL   = 6'h0E;

	// ------------------------------------------------------------
	// status/control bit positions
	// ------------------------------------------------------------
	localparam int FMX_SC_RESET   = 0;
	localparam int FMX_SC_IRQ_EN  = 2;
	localparam int FMX_SC_DIRECT  = 3;
	localparam int FMX_SC_TRIG    = 4;
	localparam int FMX_SC_IRQ_N   = 1;
	localparam int FMX_SC_BUSY_N  = 4;

	// scan sequencing control bit positions
	localparam int FMX_SQ_FLUSH   = 0;
	localparam int FMX_SQ_BPTRIG  = 1;
	localparam int FMX_SQ_FREERUN = 2;
	localparam int FMX_SQ_CONT    = 3;
	localparam int FMX_SQ_REWIND  = 4;

	// scan entry / direct control field positions
	localparam int FMX_EN_VALID_N = 15;
	localparam int FMX_EN_TREE_A  = 14;
	localparam int FMX_EN_TREE_B  = 13;
	localparam int FMX_EN_FUNC_HI = 12;
	localparam int FMX_EN_FUNC_LO = 11;
	localparam int FMX_DC_VALID_N = 4;

	// ------------------------------------------------------------
	// read values and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] FMX_SC_RD_ONES  = 16'h00EC; // bits 7..5, 3, 2 read one
	localparam logic [15:0] FMX_SQ_RD_ONES  = 16'h00F0;
	localparam logic [15:0] FMX_DLY_RD_ONES = 16'h00F0;
	localparam logic [3:0]  FMX_DELAY_RST   = 4'h0;     // 2^0 = 1 us
	localparam logic [1:0]  FMX_FN_VOLTS    = 2'h0;
	localparam logic [1:0]  FMX_FN_OHM2     = 2'h1;
	localparam logic [1:0]  FMX_FN_THERM    = 2'h2;
	localparam logic [1:0]  FMX_FN_OHM4     = 2'h3;

	// scan list depth
	localparam int FMX_LIST_DEPTH = 16;
	localparam int FMX_PTR_W      = 5;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int FMX_CLK_MHZ      = 50;
	localparam int FMX_US_CYCLES    = FMX_CLK_MHZ;  // cycles in 1 us
	localparam int FMX_CLOSED_NS    = 100;          // channel-closed pulse width
	localparam int FMX_CLOSED_CYC   = FMX_CLOSED_NS * FMX_CLK_MHZ / 1000;
	localparam int FMX_DCNT_W       = 22;           // holds 2^15 us at 50 MHz
endpackage

// File: fmx_regs.sv
`timescale 1ns/10ps
// What this block does
// - module reset bit holds module in reset
// - reset clears enables, list, delay, channels
// - interrupt allow bit, active-low readback
// - route select: zero list, one direct
// - ignore off-mode channel registers
// - software trigger advances, self-clears
// - pending interrupt low until acknowledge/reset/allow bit cleared
// - busy low during settling only, rejects triggers
// - trigger during closed pulse cuts it
// - flush bit clears list, reads back
// - backplane trigger enable stored, reads back
// - free run steps whole list
// - continuous mode wraps pointer to first
// - rewind bit returns pointer to first
// - interrupt acknowledge rewinds pointer in continuous mode
// - last valid entry interrupts when not continuous
// - settling delay 2^n us, readable
// - entry channel number in bits 3..0
// - measure function field encoding
// - tree isolation bits zero disable switch
// - entry valid when valid_n bit zero
// - direct register selects single channel
// - direct control write with valid interrupts
module fmx_regs
	import fmx_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'hC0DE, // arbitrary value
	parameter logic [15:0] MODEL_CODE = 16'h0A51  // arbitrary value
)
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [5:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        irq_ack,
	input  wire logic        backplane_trigger,
	output logic [15:0]      reg_rdata,
	output logic             irq_n,
	output logic [15:0]      channel_close,
	output logic [1:0]       measure_function,
	output logic             tree_a_enable,
	output logic             tree_b_enable,
	output logic             channel_closed
);
	typedef enum logic [1:0] {FMX_IDLE, FMX_SETTLE, FMX_CLOSED} fmx_seq_t;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic                 module_reset_r;
	logic                 irq_allow_r;
	logic                 direct_r;
	logic                 software_trigger_r;
	logic                 list_flush_r;
	logic                 backplane_trigger_enable_r;
	logic                 free_run_enable_r;
	logic                 continuous_cycle_enable_r;
	logic [3:0]           delay_exp_r;
	logic                 irq_pend_r;
	logic [15:0]          list_mem [FMX_LIST_DEPTH];
	logic [FMX_PTR_W-1:0] list_len_r;
	logic [FMX_PTR_W-1:0] ptr_r;
	logic [3:0]           direct_chan_r;
	logic [4:0]           direct_ctl_r;
	logic                 direct_live_r;
	fmx_seq_t             seq_r;
	logic                 free_running_r;
	logic [7:0]           closed_cnt_r;
	logic [15:0]          cur_entry_r;
	logic                 cur_live_r;

	logic                 soft_rst;
	logic                 wr_sc;
	logic                 wr_sq;
	logic                 wr_dly;
	logic                 wr_entry;
	logic                 wr_dchan;
	logic                 wr_dctl;
	logic                 trig;
	logic                 trig_ok;
	logic                 settle_done;
	logic                 at_last;
	logic                 irq_event;
	logic                 advance;
	logic [15:0]          entry_now;
	logic                 seq_busy;
	logic                 irq_live;

	// address decode helper, used for every write strobe
	function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
		hit = (a == ofs);
	endfunction

	// one-hot channel decode, shared by list and direct paths
	function automatic logic [15:0] chan_onehot(input logic [3:0] ch);
		chan_onehot = 16'h0001 << ch;
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign soft_rst = rst | module_reset_r;
	assign wr_sc    = reg_wr & hit(reg_addr, FMX_OFS_STATCTL);
	assign wr_sq    = reg_wr & hit(reg_addr, FMX_OFS_SEQCTL);
	assign wr_dly   = reg_wr & hit(reg_addr, FMX_OFS_DELAY);
	assign wr_entry = reg_wr & hit(reg_addr, FMX_OFS_ENTRY) & ~direct_r;
	assign wr_dchan = reg_wr & hit(reg_addr, FMX_OFS_DIRCHAN) & direct_r;
	assign wr_dctl  = reg_wr & hit(reg_addr, FMX_OFS_DIRCTL) & direct_r;

	// trigger sources, only under list control
	assign trig = ~direct_r & (software_trigger_r | (backplane_trigger_enable_r & backplane_trigger)
		| (free_running_r & seq_r == FMX_IDLE));
	// busy spans the settling delay; triggers are refused then
	assign seq_busy = (seq_r == FMX_SETTLE);
	assign trig_ok  = trig & ~seq_busy & (ptr_r < list_len_r);
	// interrupt shown only while allowed
	assign irq_live = irq_pend_r & irq_allow_r;
	assign entry_now = list_mem[ptr_r[3:0]];
	assign at_last  = (ptr_r + 1'b1 == list_len_r);
	assign advance  = trig_ok;
	// end of list interrupt when not cycling, valid entry only
	assign irq_event = (advance & at_last & ~continuous_cycle_enable_r & ~entry_now[FMX_EN_VALID_N])
		| (wr_dctl & ~reg_wdata[FMX_DC_VALID_N]);

	fmx_settle_timer u_settle (
		.clock    (clock),
		.rst      (soft_rst),
		.start    (advance),
		.abort    (direct_r),
		.exponent (delay_exp_r),
		.done     (settle_done)
	);

	// ------------------------------------------------------------
	// status/control register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			module_reset_r <= 1'b0;
		end else if (wr_sc) begin
			module_reset_r <= reg_wdata[FMX_SC_RESET];
		end
	end

	// enables, route, trigger bit
	always_ff @(posedge clock) begin
		if (soft_rst) begin
			irq_allow_r        <= 1'b0;
			direct_r           <= 1'b0;
			software_trigger_r <= 1'b0;
		end else if (wr_sc) begin
			irq_allow_r        <= reg_wdata[FMX_SC_IRQ_EN];
			direct_r           <= reg_wdata[FMX_SC_DIRECT];
			software_trigger_r <= reg_wdata[FMX_SC_TRIG];
		end else begin
			// lives one cycle: taken at once, or refused while busy
			software_trigger_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// scan sequencing control and delay
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst) begin
			list_flush_r               <= 1'b0;
			backplane_trigger_enable_r <= 1'b0;
			free_run_enable_r          <= 1'b0;
			continuous_cycle_enable_r  <= 1'b0;
			delay_exp_r                <= FMX_DELAY_RST;
		end else begin
			if (wr_sq) begin
				list_flush_r               <= reg_wdata[FMX_SQ_FLUSH];
				backplane_trigger_enable_r <= reg_wdata[FMX_SQ_BPTRIG];
				free_run_enable_r          <= reg_wdata[FMX_SQ_FREERUN];
				continuous_cycle_enable_r  <= reg_wdata[FMX_SQ_CONT];
			end
			if (wr_dly) begin
				delay_exp_r <= reg_wdata[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt pending: set wins over acknowledge
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst) begin
			irq_pend_r <= 1'b0;
		end else if (irq_event && irq_allow_r) begin
			irq_pend_r <= 1'b1;
		end else if (irq_ack || !irq_allow_r) begin
			irq_pend_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// scan list storage and length
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst || list_flush_r || (wr_sq && reg_wdata[FMX_SQ_FLUSH])) begin
			list_len_r <= '0;
		end else if (wr_entry && list_len_r < FMX_PTR_W'(FMX_LIST_DEPTH)) begin
			list_mem[list_len_r[3:0]] <= reg_wdata;
			list_len_r                <= list_len_r + 1'b1;
		end
	end

	// list pointer
	always_ff @(posedge clock) begin
		if (soft_rst || list_flush_r) begin
			ptr_r <= '0;
		end else if (wr_sq && reg_wdata[FMX_SQ_REWIND]) begin
			ptr_r <= '0;
		end else if (continuous_cycle_enable_r && irq_pend_r && irq_ack) begin
			ptr_r <= '0;
		end else if (advance) begin
			ptr_r <= (at_last && continuous_cycle_enable_r) ? '0 : ptr_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst || direct_r) begin
			seq_r          <= FMX_IDLE;
			free_running_r <= 1'b0;
			closed_cnt_r   <= '0;
			cur_entry_r    <= '1;
			cur_live_r     <= 1'b0;
		end else begin
			// free run stops as soon as its enable is cleared
			if (!free_run_enable_r) begin
				free_running_r <= 1'b0;
			end
			case (seq_r)
				FMX_IDLE, FMX_CLOSED: begin
					if (advance) begin
						seq_r        <= FMX_SETTLE;
						cur_entry_r  <= entry_now;
						cur_live_r   <= 1'b1;
						closed_cnt_r <= '0;
						free_running_r <= free_run_enable_r & ~(at_last & ~continuous_cycle_enable_r);
					end else if (seq_r == FMX_CLOSED) begin
						closed_cnt_r <= closed_cnt_r + 1'b1;
						if (closed_cnt_r == 8'(FMX_CLOSED_CYC - 1)) begin
							seq_r <= FMX_IDLE;
						end
					end
				end
				FMX_SETTLE: begin
					if (settle_done) begin
						seq_r <= FMX_CLOSED;
					end
				end
				default: seq_r <= FMX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// direct channel control
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst) begin
			direct_chan_r <= '0;
			direct_ctl_r  <= 5'h10;
			direct_live_r <= 1'b0;
		end else begin
			if (wr_dchan) begin
				direct_chan_r <= reg_wdata[3:0];
				direct_live_r <= 1'b1;
			end
			if (wr_dctl) begin
				direct_ctl_r <= reg_wdata[4:0];
			end
			if (!direct_r) begin
				direct_live_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// channel drive outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (soft_rst) begin
			channel_close    <= '0;
			measure_function <= FMX_FN_VOLTS;
			tree_a_enable    <= 1'b0;
			tree_b_enable    <= 1'b0;
			channel_closed   <= 1'b0;
		end else if (direct_r) begin
			channel_close    <= (direct_live_r && !direct_ctl_r[FMX_DC_VALID_N])
				? chan_onehot(direct_chan_r) : '0;
			measure_function <= direct_ctl_r[1:0];
			tree_a_enable    <= direct_ctl_r[3];
			tree_b_enable    <= direct_ctl_r[2];
			channel_closed   <= 1'b0;
		end else begin
			channel_close    <= (cur_live_r && !cur_entry_r[FMX_EN_VALID_N])
				? chan_onehot(cur_entry_r[3:0]) : '0;
			measure_function <= cur_entry_r[FMX_EN_FUNC_HI:FMX_EN_FUNC_LO];
			tree_a_enable    <= cur_entry_r[FMX_EN_TREE_A];
			tree_b_enable    <= cur_entry_r[FMX_EN_TREE_B];
			channel_closed   <= (seq_r == FMX_CLOSED) & ~advance;
		end
	end

	// interrupt line, active low
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~irq_live;
		end
	end

	// ------------------------------------------------------------
	// read mux, registered
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				FMX_OFS_MAKER:   reg_rdata <= MAKER_CODE;
				FMX_OFS_MODEL:   reg_rdata <= MODEL_CODE;
				FMX_OFS_STATCTL: reg_rdata <= FMX_SC_RD_ONES
					| (16'(!seq_busy) << FMX_SC_BUSY_N)
					| (16'(!irq_live) << FMX_SC_IRQ_N)
					| 16'(!irq_allow_r);
				FMX_OFS_SEQCTL:  reg_rdata <= FMX_SQ_RD_ONES | {12'h000, continuous_cycle_enable_r,
					free_run_enable_r, backplane_trigger_enable_r, list_flush_r};
				FMX_OFS_DELAY:   reg_rdata <= FMX_DLY_RD_ONES | {12'h000, delay_exp_r};
				default:         reg_rdata <= 16'hFFFF;
			endcase
		end
	end
endmodule

// File: fmx_regs_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the register block
// ------------------------------------------------------------
module fmx_regs_assertions
	import fmx_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [5:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        irq_ack,
	input  wire logic        backplane_trigger,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        irq_n,
	input  wire logic [15:0] channel_close,
	input  wire logic [1:0]  measure_function,
	input  wire logic        tree_a_enable,
	input  wire logic        tree_b_enable,
	input  wire logic        channel_closed
);
	logic [3:0] dly_r;
	logic       en_r;
	logic       sc_wr;
	assign sc_wr = reg_wr && reg_addr == FMX_OFS_STATCTL;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// shadow of the settling exponent
	always_ff @(posedge clock) begin
		if (rst || (sc_wr && reg_wdata[FMX_SC_RESET]))
			dly_r <= FMX_DELAY_RST;
		else if (reg_wr && reg_addr == FMX_OFS_DELAY)
			dly_r <= reg_wdata[3:0];
	end
	// shadow of the interrupt allow bit
	always_ff @(posedge clock) begin
		if (rst)
			en_r <= 1'b0;
		else if (sc_wr)
			en_r <= reg_wdata[FMX_SC_IRQ_EN] && !reg_wdata[FMX_SC_RESET];
	end
	AST_RST_OUT: assert property ($fell(rst) |-> channel_close == 16'h0000 && irq_n && !channel_closed)
		else $error("outputs not at reset value");
	AST_ONE_CHANNEL: assert property ($onehot0(channel_close))
		else $error("more than one channel closed");
	AST_CLOSED_PULSE: assert property ($rose(channel_closed) |-> ##5 !channel_closed)
		else $error("closed pulse too long");
	AST_RDATA_HOLD: assert property (!$past(reg_rd) && !$past(reg_rd, 2) && !$past(rst) && !$past(rst, 2)
		|-> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_DELAY_READ: assert property (reg_rd && reg_addr == FMX_OFS_DELAY |=> reg_rdata[7:0] == {4'hF, dly_r})
		else $error("delay readback wrong");
	AST_BUSY_IN_PULSE: assert property (channel_closed && reg_rd && reg_addr == FMX_OFS_STATCTL
		|=> reg_rdata[FMX_SC_BUSY_N])
		else $error("busy during closed pulse");
	AST_IRQ_EN_READ: assert property (reg_rd && reg_addr == FMX_OFS_STATCTL
		|=> reg_rdata[0] == !en_r && reg_rdata[7:5] == 3'h7 && reg_rdata[3:2] == 2'h3)
		else $error("allow bit readback wrong");
	AST_IRQ_NEEDS_EN: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> irq_n)
		else $error("interrupt while not allowed");
	AST_SEQ_READ: assert property (reg_rd && reg_addr == FMX_OFS_SEQCTL |=> reg_rdata[7:4] == 4'hF)
		else $error("sequencing readback ones wrong");
	cover property ($rose(channel_closed));
	cover property ($fell(irq_n));
	cover property (reg_wr && reg_addr == FMX_OFS_DIRCTL && !reg_wdata[FMX_DC_VALID_N]);
endmodule

bind fmx_regs fmx_regs_assertions fmx_regs_assertions_inst (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .irq_ack(irq_ack), .backplane_trigger(backplane_trigger),
	.reg_rdata(reg_rdata), .irq_n(irq_n), .channel_close(channel_close),
	.measure_function(measure_function), .tree_a_enable(tree_a_enable),
	.tree_b_enable(tree_b_enable), .channel_closed(channel_closed)
);

// File: fmx_settle_timer.sv
`timescale 1ns/10ps
// settling delay timer: counts 2^n microseconds, then pulses done
module fmx_settle_timer
	import fmx_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic [3:0] exponent,
	output logic            done
);
	logic [FMX_DCNT_W-1:0] count_r;
	logic                  run_r;
	logic [FMX_DCNT_W-1:0] load_val;

	// ------------------------------------------------------------
	// count loading
	// ------------------------------------------------------------
	// cycles = 2^n * cycles-per-us, counted down to one
	assign load_val = FMX_DCNT_W'(FMX_US_CYCLES) << exponent;

	// down counter
	always_ff @(posedge clock) begin
		if (rst || abort) begin
			run_r   <= 1'b0;
			count_r <= '0;
			done    <= 1'b0;
		end else if (start) begin
			run_r   <= 1'b1;
			count_r <= load_val;
			done    <= 1'b0;
		end else if (run_r) begin
			count_r <= count_r - 1'b1;
			done    <= (count_r == FMX_DCNT_W'(2));
			if (count_r == FMX_DCNT_W'(2)) begin
				run_r <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// File: tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// self-checking bench for the register block
// ------------------------------------------------------------
module tb;
	import fmx_pkg::*;
	localparam logic [5:0]  RA [6] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h3E};
	localparam logic [15:0] RE [6] = '{16'h5A3C, 16'h3C5A, 16'h00FF, 16'h00F0, 16'h00F0, 16'hFFFF};
	logic        clock, rst, backplane_trigger, reg_wr, reg_rd, irq_ack, irq_n;
	logic        tree_a_enable, tree_b_enable, channel_closed;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, channel_close, d;
	logic [1:0]  measure_function;
	logic [15:0] list_q[$];
	int          num_errors, checked, n, t;

	fmx_regs #(.MAKER_CODE(16'h5A3C), .MODEL_CODE(16'h3C5A)) fmx_regs_inst ( // arbitrary codes
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .irq_ack(irq_ack), .backplane_trigger(backplane_trigger),
		.reg_rdata(reg_rdata), .irq_n(irq_n), .channel_close(channel_close),
		.measure_function(measure_function), .tree_a_enable(tree_a_enable),
		.tree_b_enable(tree_b_enable), .channel_closed(channel_closed));
	fmx_host_model fmx_host_model_inst (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .irq_ack(irq_ack));

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// compare and count
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] v);
		fmx_host_model_inst.wr(a, v);
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
		fmx_host_model_inst.rd(a, d);
		chk(nm, e & m, d & m);
	endtask
	// bounded wait for the closed pulse level, counting cycles
	task automatic wait_lvl(input logic v, input int lim);
		t = 0;
		while (channel_closed !== v && t < lim) begin
			@(posedge clock);
			#1;
			t++;
		end
		if (t >= lim) chk("closed_wait", 16'(v), 16'(channel_closed));
	endtask
	// outputs against an expected entry
	task automatic check_entry(input logic [15:0] e);
		chk("chan", e[15] ? 16'h0 : 16'h1 << e[3:0], channel_close);
		chk("func", {14'h0, e[12:11]}, {14'h0, measure_function});
		chk("tree", {14'h0, e[14:13]}, {14'h0, tree_a_enable, tree_b_enable});
	endtask
	// walk the list, triggered per step or once
	task automatic run(input int cnt, input bit step);
		for (int i = 0; i < cnt; i++) begin
			if (step || i == 0) wr(FMX_OFS_STATCTL, 16'h0014);
			if (step && i == 0) rd_chk("busy", FMX_OFS_STATCTL, 16'h00EE, 16'h00FF);
			if (step && i == 0) wr(FMX_OFS_STATCTL, 16'h0014);
			wait_lvl(1'b1, (50 << n) + 60);
			if (step && i > 0) chk("settle", 16'h1, 16'(t >= (50 << n) && t <= (50 << n) + 4));
			rd_chk("busy_end", FMX_OFS_STATCTL, 16'h0010, 16'h0010);
			check_entry(list_q[i % list_q.size()]);
			wait_lvl(1'b0, 20);
		end
	endtask
	task automatic irq_round(input string nm);
		repeat (4) @(posedge clock);
		#1;
		chk(nm, 16'h0, 16'(irq_n));
		rd_chk("irq_rd", FMX_OFS_STATCTL, 16'h0000, 16'h0002);
		fmx_host_model_inst.ack();
		repeat (3) @(posedge clock);
		#1;
		chk("irq_ack", 16'h1, 16'(irq_n));
	endtask
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog
	initial begin
		#(20 * 60000);
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		backplane_trigger = 1'b0;
		d = 16'($urandom(32'h7540));
		repeat (6) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		foreach (RA[i]) rd_chk("reset_read", RA[i], RE[i], (i >= 2 && i <= 4) ? 16'h00FF : 16'hFFFF);
		wr(FMX_OFS_STATCTL, 16'h0004);
		rd_chk("allow", FMX_OFS_STATCTL, 16'h00FE, 16'h00FF);
		d = 16'($urandom);
		wr(FMX_OFS_DELAY, d);
		rd_chk("delay", FMX_OFS_DELAY, {12'h00F, d[3:0]}, 16'h00FF);
		wr(FMX_OFS_SEQCTL, d & 16'h000E);
		rd_chk("seq", FMX_OFS_SEQCTL, 16'h00F0 | (d & 16'h000E), 16'h00FF);
		$display("test registers done");
		wr(FMX_OFS_SEQCTL, 16'h0001);
		rd_chk("flush", FMX_OFS_SEQCTL, 16'h00F1, 16'h00FF);
		wr(FMX_OFS_SEQCTL, 16'h0000);
		n = $urandom_range(2);
		wr(FMX_OFS_DELAY, 16'(n));
		for (int i = 0; i < 4; i++) begin
			d = {1'b0, 2'($urandom), 2'(i), 7'h00, 4'($urandom)};
			list_q.push_back(d);
			wr(FMX_OFS_ENTRY, d);
		end
		run(4, 1'b1);
		irq_round("irq_end");
		wr(FMX_OFS_SEQCTL, 16'h0014);
		run(4, 1'b0);
		irq_round("irq_free");
		wr(FMX_OFS_SEQCTL, 16'h0012);
		@(negedge clock);
		backplane_trigger = 1'b1;
		@(negedge clock);
		backplane_trigger = 1'b0;
		wait_lvl(1'b1, (50 << n) + 60);
		check_entry(list_q[0]);
		wait_lvl(1'b0, 20);
		wr(FMX_OFS_SEQCTL, 16'h001C);
		run(6, 1'b0);
		wr(FMX_OFS_SEQCTL, 16'h0000);
		$display("test scan done");
		wr(FMX_OFS_STATCTL, 16'h000C);
		d = 16'($urandom_range(15));
		wr(FMX_OFS_DIRCHAN, d);
		wr(FMX_OFS_DIRCTL, 16'h0009);
		repeat (3) @(posedge clock);
		#1;
		check_entry({1'b0, 2'b10, 2'b01, 7'h00, d[3:0]});
		chk("irq_direct", 16'h0, 16'(irq_n));
		$display("test direct done");
		wr(FMX_OFS_STATCTL, 16'h0001);
		wr(FMX_OFS_STATCTL, 16'h0000);
		chk("open_all", 16'h0000, channel_close);
		rd_chk("rst_stat", FMX_OFS_STATCTL, 16'h00FF, 16'h00FF);
		rd_chk("rst_delay", FMX_OFS_DELAY, 16'h00F0, 16'h00FF);
		rd_chk("rst_seq", FMX_OFS_SEQCTL, 16'h00F0, 16'h00FF);
		$display("test module reset done");
		wr(FMX_OFS_DELAY, 16'(n));
		list_q.delete();
		for (int i = 0; i < 2; i++) begin
			d = {1'(i), 2'($urandom), 2'($urandom), 7'h00, 4'($urandom)};
			list_q.push_back(d);
			wr(FMX_OFS_ENTRY, d);
		end
		run(2, 1'b1);
		repeat (4) @(posedge clock);
		#1;
		chk("irq_invalid", 16'h1, 16'(irq_n));
		$display("test invalid entry done");
		print_verdict();
	end
endmodule
